/* common/ereu_map.vh */
`ifndef EREU_MAP_VH
`define EREU_MAP_VH
// Error type ranks used for priority comparison
`define EREU_RANK_NONE 3'd0
`define EREU_RANK_CE 3'd1
`define EREU_RANK_DE 3'd2
`define EREU_RANK_UEO 3'd3
`define EREU_RANK_UER 3'd4
`define EREU_RANK_UEU 3'd5
`define EREU_RANK_UC 3'd6
// Uncorrected subtype encodings held in the status word
`define EREU_UET_LATENT 2'b10
`define EREU_UET_SIGNALED 2'b11
`define EREU_UET_UNRECOV 2'b01
`define EREU_UET_UNCONT 2'b00
// Register offsets (byte addresses)
`define EREU_OFF_FEATURE 12'h000
`define EREU_OFF_CONTROL 12'h008
`define EREU_OFF_STATUS 12'h010
`define EREU_OFF_COUNTER 12'h018
`define EREU_REC_STRIDE 12'h040
// Status word bit positions
`define EREU_ST_V 31
`define EREU_ST_UE 29
`define EREU_ST_DE 23
`define EREU_ST_OF 27
`define EREU_ST_CE_HI 25
`define EREU_ST_CE_LO 24
`define EREU_ST_UET_HI 21
`define EREU_ST_UET_LO 20
`define EREU_ST_SYN_HI 7
// Feature word bit positions
`define EREU_FR_ED_HI 1
`define EREU_FR_ED_LO 0
`define EREU_FR_DUI 16
`define EREU_FR_CEO 31
`define EREU_FR_CNT 12
// Control word bit positions
`define EREU_CT_ED 0
`define EREU_CT_DUI 1
`define EREU_CT_UI 2
`endif

/* design/ereu_decide.v */
`timescale 1ns/1ps
`include "ereu_map.vh"
// Pure combinational priority decision for one new error against one record
module ereu_decide #(
  parameter VERSION_11 = 1, // 1 selects version 1.1 rules, 0 version 1.0
  parameter HAS_COUNTER = 1 // 1 when a corrected error counter exists
) (
  input wire [2:0] prev_rank, // Rank stored in the record (none when invalid)
  input wire [2:0] new_rank, // Rank of the arriving error
  input wire prev_of, // Overflow flag before this error
  input wire cnt_ovf, // Counting this error wraps the counter
  input wire corrected_overwrite_policy, // Corrected overwrite policy field
  output reg overwrite, // Take the new syndrome
  output reg set_of, // Force overflow to one
  output reg clr_of // Clear overflow (version 1.0 overwrite choice)
);
  localparam [2:0] NONE = `EREU_RANK_NONE;
  localparam [2:0] CE = `EREU_RANK_CE;
  localparam [2:0] DE = `EREU_RANK_DE;

  // Decision matrix; corrected-vs-counter overflow handled inline
  always @* begin
    overwrite = 1'b0;
    set_of = 1'b0;
    clr_of = 1'b0;
    if (prev_rank == NONE) begin
      overwrite = 1'b1;
      if (new_rank == CE && HAS_COUNTER != 0 && cnt_ovf)
        set_of = (VERSION_11 != 0); // v1.0 leaves it free; keep it
    end else if (VERSION_11 != 0) begin
      if (new_rank == CE) begin
        // Without a counter the policy field has no effect: keep with overflow
        if (prev_rank == CE && corrected_overwrite_policy && !prev_of && HAS_COUNTER != 0)
          overwrite = 1'b1;
        // Counter present: only overflow sets; absent: keep with overflow
        set_of = (HAS_COUNTER != 0) ? cnt_ovf : 1'b1;
      end else begin
        overwrite = (new_rank > prev_rank);
        set_of = 1'b1;
      end
    end else begin
      if (new_rank == CE) begin
        if (prev_rank == CE && corrected_overwrite_policy && !prev_of)
          overwrite = 1'b1;
        set_of = (HAS_COUNTER == 0) || cnt_ovf;
      end else if (new_rank > prev_rank) begin
        overwrite = 1'b1;
        set_of = (prev_rank > DE); // both uncorrected
        clr_of = (prev_rank <= DE); // Overwrite chooses to clear
      end else if (!(new_rank == DE && prev_rank > DE)) begin
        set_of = 1'b1;
      end
    end
  end
endmodule // ereu_decide

/* design/ereu_node.v */
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "ereu_map.vh"
// Summary of operation
// - Interrupt on uncorrected and on deferred, each only when enabled
// - Interrupt fires even if syndrome discarded
// - One feature and control register per node
// - Later records: detect field zero, control reserved
// - Unimplemented record slots read zero, ignore writes
// - Update type fields, choose syndrome, count corrected
// - Counter overflow sets overflow, except version 1.0 into an empty record
// - Valid and corrected field encode corrected errors
// - Deferred and uncorrected subtype encodings
// - Version 1.0 matrix for non-corrected errors
// - Version 1.0 corrected over corrected policy
// - Version 1.0 corrected into empty record
// - Version 1.1 overflow setting conditions
// - Version 1.1 matrix for non-corrected errors
// - Version 1.1 counterless collapse of actions
// - Version 1.1 corrected overwrite policy field
// - Type flags updated even when syndrome kept
module ereu_node #(
  parameter VERSION_11 = 1, // 1 selects version 1.1 rules
  parameter HAS_COUNTER = 1, // Corrected error counter present
  parameter NREC = 2, // Records owned by this node
  parameter NSLOT = 4, // Record slots in the group window
  parameter CNT_W = 16, // Corrected counter width
  parameter CEO_VAL = 1 // Corrected overwrite policy value
) (
  input wire clk, // 250 MHz clock
  input wire reset, // Synchronous, active high
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready, always one
  output wire pslverr, // APB error on unmapped address
  input wire err_valid, // One-cycle pulse: new error detected
  input wire [2:0] err_rank, // Rank of the new error (1..6)
  input wire [1:0] err_rec, // Record that takes the error
  input wire [7:0] err_syn, // Syndrome of the new error
  output reg err_irq // Error recovery interrupt pulse
);
  localparam [2:0] R_NONE = `EREU_RANK_NONE;
  localparam [2:0] R_CE = `EREU_RANK_CE;
  localparam [2:0] R_DE = `EREU_RANK_DE;
  localparam [2:0] R_UEO = `EREU_RANK_UEO;
  localparam [2:0] R_UER = `EREU_RANK_UER;
  localparam [2:0] R_UEU = `EREU_RANK_UEU;

  // Per-record state
  reg [31:0] status_r [0:NSLOT-1]; // Status word per record
  reg [CNT_W-1:0] count_r [0:NSLOT-1]; // Corrected counter per record
  reg [2:0] ctl_r; // Shared node control (detect, deferred irq, uncorr irq)
  reg [31:0] rdata_r; // Registered read data
  wire [31:0] feature_w; // Shared node feature word

  // Rank of a stored status word
  function [2:0] rank_of;
    input [31:0] st;
    begin
      if (!st[`EREU_ST_V])
        rank_of = R_NONE;
      else if (st[`EREU_ST_UE]) begin
        case (st[`EREU_ST_UET_HI:`EREU_ST_UET_LO])
          `EREU_UET_LATENT: rank_of = R_UEO;
          `EREU_UET_SIGNALED: rank_of = R_UER;
          `EREU_UET_UNRECOV: rank_of = R_UEU;
          default: rank_of = `EREU_RANK_UC;
        endcase
      end else if (st[`EREU_ST_DE])
        rank_of = R_DE;
      else if (st[`EREU_ST_CE_HI:`EREU_ST_CE_LO] != 2'b00)
        rank_of = R_CE;
      else
        rank_of = R_NONE;
    end
  endfunction

  // Subtype encoding of an uncorrected rank
  function [1:0] uet_of;
    input [2:0] rk;
    begin
      case (rk)
        R_UEO: uet_of = `EREU_UET_LATENT;
        R_UER: uet_of = `EREU_UET_SIGNALED;
        R_UEU: uet_of = `EREU_UET_UNRECOV;
        default: uet_of = `EREU_UET_UNCONT;
      endcase
    end
  endfunction

  // One feature word for the whole node
  assign feature_w = {CEO_VAL[0], 14'h0000, 1'b1, 3'h0,
    (HAS_COUNTER != 0), 10'h000, 2'b10};

  // Decision for the addressed record
  wire [31:0] tgt_st = status_r[err_rec]; // Status of the target record
  wire [2:0] prev_rank = rank_of(tgt_st); // Stored rank
  wire tgt_ok = ({1'b0, err_rec} < NREC[2:0]) && ctl_r[`EREU_CT_ED]; // Live record
  wire [CNT_W:0] cnt_sum = {1'b0, count_r[err_rec]} + {{CNT_W{1'b0}}, 1'b1}; // Count+1
  wire cnt_ovf = cnt_sum[CNT_W]; // Wrap on increment
  wire dec_ow; // Take new syndrome
  wire dec_sof; // Set overflow
  wire dec_cof; // Clear overflow
  // Software may clear only the type bits and leave valid set. Such a record ranks as
  // empty, so the matrix overwrites it, yet version 1.1 still owes an overflow because
  // valid was set before the new error arrived
  wire typeless_v = tgt_st[`EREU_ST_V] && (prev_rank == R_NONE); // Valid but untyped
  wire hole_sof = (VERSION_11 != 0) && typeless_v &&
    ((err_rank != R_CE) || (HAS_COUNTER == 0)); // Overflow owed on a typeless record

  ereu_decide #(
    .VERSION_11(VERSION_11),
    .HAS_COUNTER(HAS_COUNTER)
  ) u_dec (
    .prev_rank(prev_rank),
    .new_rank(err_rank),
    .prev_of(tgt_st[`EREU_ST_OF]),
    .cnt_ovf(cnt_ovf),
    .corrected_overwrite_policy(CEO_VAL[0]),
    .overwrite(dec_ow),
    .set_of(dec_sof),
    .clr_of(dec_cof)
  );

  // APB decode
  wire acc = psel && penable; // Access phase
  wire [1:0] slot = paddr[7:6]; // Record slot
  wire [5:0] roff = paddr[5:0]; // Offset inside slot
  wire slot_ok = ({1'b0, slot} < NREC[2:0]); // Implemented record
  wire off_ok = (paddr[11:8] == 4'h0) && (roff == `EREU_OFF_FEATURE) ||
    (paddr[11:8] == 4'h0) && (roff == `EREU_OFF_CONTROL) ||
    (paddr[11:8] == 4'h0) && (roff == `EREU_OFF_STATUS) ||
    (paddr[11:8] == 4'h0) && (roff == `EREU_OFF_COUNTER); // Mapped offset
  wire wr_st = acc && pwrite && slot_ok && (roff == `EREU_OFF_STATUS); // Status clear

  assign pready = 1'b1;
  assign pslverr = acc && !off_ok;
  assign prdata = rdata_r;

  // Read mux for the addressed slot
  reg [31:0] rd_nxt; // Next read data
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (slot_ok) begin // unimplemented slots read zero
      case (roff)
        `EREU_OFF_FEATURE: rd_nxt = (slot == 2'd0) ? feature_w :
          {30'h0, 2'b00}; // later records: only low bits, detect zero
        `EREU_OFF_CONTROL: rd_nxt = (slot == 2'd0) ? {29'h0, ctl_r} :
          32'h0000_0000;
        `EREU_OFF_STATUS: rd_nxt = status_r[slot];
        `EREU_OFF_COUNTER: rd_nxt = {{(32-CNT_W){1'b0}}, count_r[slot]};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Registered read data, captured in the setup cycle so it is ready in access
  always @(posedge clk) begin
    if (reset)
      rdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      rdata_r <= rd_nxt;
  end

  // Shared control; only slot zero holds it
  always @(posedge clk) begin
    if (reset)
      ctl_r <= 3'b111;
    else if (acc && pwrite && slot == 2'd0 && roff == `EREU_OFF_CONTROL)
      ctl_r <= pwdata[2:0];
  end

  // Recovery interrupt: uncorrected and deferred, each when its enable is set
  always @(posedge clk) begin
    if (reset)
      err_irq <= 1'b0;
    else
      err_irq <= err_valid && tgt_ok && // independent of overwrite
        ((err_rank > R_DE && ctl_r[`EREU_CT_UI]) ||
         (err_rank == R_DE && ctl_r[`EREU_CT_DUI]));
  end

  // Record update; a new error wins over a same-cycle software clear
  integer i;
  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < NSLOT; i = i + 1) begin
        status_r[i] <= 32'h0000_0000;
        count_r[i] <= {CNT_W{1'b0}};
      end
    end else begin
      if (acc && pwrite && slot_ok && roff == `EREU_OFF_COUNTER)
        count_r[slot] <= pwdata[CNT_W-1:0];
      // Write-one-to-clear of valid, overflow and type fields
      if (wr_st && !(err_valid && tgt_ok && err_rec == slot))
        status_r[slot] <= status_r[slot] & ~(pwdata & 32'hbbb0_0000);
      if (err_valid && tgt_ok && err_rank != R_NONE) begin
        // Count corrected errors only
        if (err_rank == R_CE && HAS_COUNTER != 0)
          count_r[err_rec] <= cnt_sum[CNT_W-1:0];
        // Overflow sources merge here; a set always beats the version 1.0 clear
        status_r[err_rec] <= upd(tgt_st, err_rank, err_syn, dec_ow,
          dec_sof || hole_sof, dec_cof);
      end
    end
  end

  // Build the updated status word
  function [31:0] upd;
    input [31:0] st;
    input [2:0] rk;
    input [7:0] syn;
    input ow;
    input sof;
    input cof;
    reg [31:0] s;
    begin
      s = st;
      if (rk == R_CE && s[`EREU_ST_CE_HI:`EREU_ST_CE_LO] == 2'b00)
        s[`EREU_ST_CE_HI:`EREU_ST_CE_LO] = 2'b10;
      if (rk == R_DE)
        s[`EREU_ST_DE] = 1'b1;
      if (rk > R_DE) begin
        s[`EREU_ST_UE] = 1'b1;
        if (ow || !st[`EREU_ST_UE])
          s[`EREU_ST_UET_HI:`EREU_ST_UET_LO] = uet_of(rk);
      end
      if (ow)
        s[`EREU_ST_SYN_HI:0] = syn;
      if (cof)
        s[`EREU_ST_OF] = 1'b0;
      if (sof)
        s[`EREU_ST_OF] = 1'b1;
      s[`EREU_ST_V] = 1'b1;
      upd = s;
    end
  endfunction
endmodule // ereu_node

/* tb/ereu_monitor.sv */
`timescale 1ns/1ps
// Port-level checks on the error record node
module ereu_monitor #(
  parameter NREC = 2 // Records owned by the node
) (
  input wire clk, // Clock
  input wire reset, // Sync reset
  input wire psel, // APB select
  input wire penable, // APB access
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB address
  input wire [31:0] pwdata, // APB write data
  input wire [31:0] prdata, // APB read data
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire err_valid, // Error pulse
  input wire [2:0] err_rank, // Error rank
  input wire [1:0] err_rec, // Target record
  input wire [7:0] err_syn, // Syndrome
  input wire err_irq // Recovery interrupt
);
  reg [2:0] ctl_r; // Shadow of the shared control word
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow follows completed control writes, so irq enables are known here
  always @(posedge clk) begin
    if (reset) begin
      ctl_r <= 3'h7;
    end else if (psel && penable && pwrite && paddr == 12'h008) begin
      ctl_r <= pwdata[2:0];
    end
  end
  sequence s_hit;
    err_valid && err_rec < NREC && ctl_r[0];
  endsequence
  sequence s_rd;
    psel && !penable && !pwrite;
  endsequence
  a_irq_pulse: assert property (err_irq |=> !err_irq)
    else $error("irq held longer than one cycle");
  a_irq_cause: assert property (err_irq |-> $past(err_valid))
    else $error("irq without an error event");
  a_ce_quiet: assert property (err_valid && err_rank == 3'd1 |=> !err_irq)
    else $error("irq on a corrected error");
  a_ue_irq: assert property (s_hit ##0 (err_rank >= 3'd3 && ctl_r[2]) |=> err_irq)
    else $error("no irq on an uncorrected error");
  a_de_irq: assert property (s_hit ##0 (err_rank == 3'd2 && ctl_r[1]) |=> err_irq)
    else $error("no irq on an enabled deferred error");
  a_de_quiet: assert property (err_valid && err_rank == 3'd2 && !ctl_r[1] |=> !err_irq)
    else $error("irq on a disabled deferred error");
  a_empty_slot: assert property (s_rd ##0 (paddr[7:6] >= NREC) |=> prdata == 32'h0)
    else $error("empty slot read not zero");
  a_later_zero: assert property (s_rd ##0 (paddr[7:6] != 2'd0 && paddr[5:4] == 2'd0)
    |=> prdata == 32'h0) else $error("later record feature or control not zero");
  a_first_feat: assert property (s_rd ##0 (paddr == 12'h000) |=> prdata[1:0] == 2'b10)
    else $error("first record detect field wrong");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("ready low in access phase");
  a_err_unmapped: assert property (psel && penable && paddr[5:0] == 6'h20 |-> pslverr)
    else $error("no slave error on an unmapped offset");
endmodule // ereu_monitor
bind ereu_node ereu_monitor #(.NREC(NREC)) u_mon (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .err_valid(err_valid), .err_rank(err_rank),
  .err_rec(err_rec), .err_syn(err_syn), .err_irq(err_irq));

/* tb/ereu_err_src.sv */
`timescale 1ns/1ps
// Detection logic model: one-cycle error events on request
module ereu_err_src (
  input wire clk, // Clock
  output reg err_valid, // Error pulse
  output reg [2:0] err_rank, // Error rank
  output reg [1:0] err_rec, // Target record
  output reg [7:0] err_syn // Syndrome
);
  initial begin
    err_valid = 1'b0;
    err_rank = 3'h0;
    err_rec = 2'h0;
    err_syn = 8'h0;
  end
  // Rank and syndrome are scrambled after the pulse so stale values cannot pass
  task emit(input [2:0] k, input [1:0] n, input [7:0] s);
    begin
      @(posedge clk);
      err_valid <= 1'b1;
      err_rank <= k;
      err_rec <= n;
      err_syn <= s;
      @(posedge clk);
      err_valid <= 1'b0;
      err_rank <= ~k;
      err_syn <= ~s;
    end
  endtask
endmodule // ereu_err_src

/* tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
  fails = fails + 1; $display("mismatch %s exp %h got %h", nm, e, g); end end
// Register and error-event sequences against the node
module tb_top;
  reg clk = 1'b0; // 250 MHz clock
  reg reset = 1'b1; // Sync reset
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  reg [11:0] paddr = 12'h0; // APB address
  reg [31:0] pwdata = 32'h0; // APB write data
  wire [31:0] prdata; // APB read data
  wire [31:0] prdata10; // Read data of the version 1.0 node
  wire pready10, pslverr10, err_irq10; // Outputs of the version 1.0 node
  wire pready, pslverr, err_valid, err_irq; // Handshake and event lines
  wire [2:0] err_rank; // Error rank
  wire [1:0] err_rec; // Target record
  wire [7:0] err_syn; // Syndrome
  integer fails = 0, compares = 0, cyc = 0, i; // Counters
  reg [31:0] rd, rd10, ex; // Last reads and expectation
  reg er, er10; // Last slave errors
  always #2 clk = ~clk;
  ereu_err_src u_src (.clk(clk), .err_valid(err_valid), .err_rank(err_rank),
    .err_rec(err_rec), .err_syn(err_syn));
  ereu_node u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .err_valid(err_valid), .err_rank(err_rank), .err_rec(err_rec), .err_syn(err_syn),
    .err_irq(err_irq));
  // Same stimulus into a version 1.0 node, so both priority matrices are exercised
  ereu_node #(.VERSION_11(0)) u_dut10 (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata10), .pready(pready10),
    .pslverr(pslverr10), .err_valid(err_valid), .err_rank(err_rank), .err_rec(err_rec),
    .err_syn(err_syn), .err_irq(err_irq10));
  task close_out;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      close_out;
    end
  end
  // One APB transfer; request held until pready is seen high
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Wait ends once both nodes show pready high; the hang guard covers a stuck one
      do begin
        @(posedge clk);
      end while (pready !== 1'b1 || pready10 !== 1'b1);
      rd = prdata;
      rd10 = prdata10;
      er = pslverr;
      er10 = pslverr10;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rchk2(input [11:0] a, input [31:0] e, input [31:0] e10);
    begin
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), e, rd)
      `CHK($sformatf("v10 reg %h", a), e10, rd10)
    end
  endtask
  task rchk(input [11:0] a, input [31:0] e);
    begin
      rchk2(a, e, e);
    end
  endtask
  task hit(input [2:0] k, input [1:0] n, input [7:0] s, input q);
    begin
      u_src.emit(k, n, s);
      #1;
      `CHK("irq", q, err_irq)
      `CHK("irq v10", q, err_irq10)
      @(posedge clk);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rchk(12'h000, 32'h80011002);
    rchk(12'h008, 32'h00000007);
    rchk(12'h040, 32'h0);
    rchk(12'h048, 32'h0);
    apb(1'b1, 12'h088, 32'hffffffff);
    rchk(12'h088, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    `CHK("slverr", 1'b1, er)
    `CHK("slverr v10", 1'b1, er10)
    $display("test registers done");
    hit(3'd1, 2'd0, 8'h11, 1'b0);
    rchk(12'h010, 32'h82000011);
    hit(3'd1, 2'd0, 8'h22, 1'b0);
    rchk(12'h010, 32'h82000022);
    hit(3'd2, 2'd0, 8'h33, 1'b1);
    rchk2(12'h010, 32'h8a800033, 32'h82800033);
    hit(3'd1, 2'd0, 8'h99, 1'b0);
    rchk2(12'h010, 32'h8a800033, 32'h82800033);
    rchk(12'h018, 32'h00000003);
    hit(3'd6, 2'd0, 8'h44, 1'b1);
    rchk2(12'h010, 32'haa800044, 32'ha2800044);
    hit(3'd3, 2'd0, 8'h55, 1'b1);
    rchk(12'h010, 32'haa800044);
    hit(3'd2, 2'd0, 8'h66, 1'b1);
    rchk(12'h010, 32'haa800044);
    $display("test priority done");
    apb(1'b1, 12'h010, 32'hffffffff);
    rchk(12'h010, 32'h00000044);
    apb(1'b1, 12'h008, 32'h00000005);
    hit(3'd2, 2'd0, 8'h55, 1'b0);
    rchk(12'h010, 32'h80800055);
    apb(1'b1, 12'h018, 32'h0000ffff);
    hit(3'd1, 2'd0, 8'h77, 1'b0);
    rchk(12'h010, 32'h8a800055);
    rchk(12'h018, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      hit(3'd3 + i[2:0], 2'd1, 8'h10 + i[7:0], 1'b1);
      ex = 32'ha0000000;
      ex[21:20] = 8'h1e >> (2 * i);
      ex[27] = (i != 0);
      ex[7:0] = 8'h10 + i[7:0];
      rchk(12'h050, ex);
    end
    $display("test overflow and subtypes done");
    close_out;
  end
endmodule // tb_top
